// [ecsp_cfg.svh]
// Offsets, field positions and reset values of the status/path slice
`ifndef ECSP_CFG_SVH
`define ECSP_CFG_SVH

// ----------------------------------------------------------------
// Register offsets within the slice (canceller B = A + stride)
// ----------------------------------------------------------------
`define ECSP_OFF_A_STATUS  8'h02
`define ECSP_OFF_B_STATUS  8'h22
`define ECSP_OFF_A_PATH    8'h08
`define ECSP_OFF_B_PATH    8'h28
`define ECSP_OFF_A_TONE    8'h01
`define ECSP_OFF_B_TONE    8'h21
`define ECSP_BANK_STRIDE   8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ECSP_ST_TONE       6
`define ECSP_ST_DTALK      5
`define ECSP_ST_GATED      1
`define ECSP_ST_NBAND      0
`define ECSP_PC_INSTAB     3
`define ECSP_PC_CLR        2
`define ECSP_PC_DET        1
`define ECSP_TC_PHREV      6
`define ECSP_TC_AUTO       4

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define ECSP_STATUS_RST    8'h00
`define ECSP_PATH_RST      8'h0A
`define ECSP_TONE_RST      8'h00
`define ECSP_PATH_WMASK    8'h0E
`define ECSP_TONE_WMASK    8'h50

`endif

// [ecsp_pkg.sv]
// Types shared by the status/path slice
`default_nettype none
package ecsp_pkg;
    typedef logic [7:0] ecsp_byte_t;

    typedef enum logic [1:0] {
        ECSP_REG_NONE   = 2'b00,
        ECSP_REG_STATUS = 2'b01,
        ECSP_REG_PATH   = 2'b10,
        ECSP_REG_TONE   = 2'b11
    } ecsp_reg_e;
endpackage : ecsp_pkg
`default_nettype wire

// [ecsp_chan_if.sv]
// Signals between the register slice and one canceller's flag logic
`timescale 1ns/1ns
`default_nettype none
interface ecsp_chan_if (
    input wire logic clk,
    input wire logic rst_n
);
    logic       tone_raw;
    logic       phase_rev;
    logic       double_talk;
    logic       narrowband;
    logic       path_change;
    logic       auto_tone_bypass_en;
    logic       phase_reversal_ignore;
    logic       path_change_detect_en;
    logic       estimate_clear_on_change;
    logic [7:0] status;
    logic       bypass;
    logic       est_clear;
    logic       fast_conv;

    modport regs (
        output tone_raw, phase_rev, double_talk, narrowband, path_change,
        output auto_tone_bypass_en, phase_reversal_ignore,
        output path_change_detect_en, estimate_clear_on_change,
        input  status, bypass, est_clear, fast_conv
    );
    modport chan (
        input  clk, rst_n,
        input  tone_raw, phase_rev, double_talk, narrowband, path_change,
        input  auto_tone_bypass_en, phase_reversal_ignore,
        input  path_change_detect_en, estimate_clear_on_change,
        output status, bypass, est_clear, fast_conv
    );
endinterface : ecsp_chan_if
`default_nettype wire

// [ecsp_canceller.sv]
// Live flag and path-change action logic of one canceller
`timescale 1ns/1ns
`default_nettype none
`include "ecsp_cfg.svh"
module ecsp_canceller
    import ecsp_pkg::*;
(
    ecsp_chan_if.chan chan
);
    // ------------------------------------------------------------
    // Detector qualification
    // ------------------------------------------------------------
    wire logic tone_seen;
    wire logic gated_tone;
    wire logic change_evt;
    assign tone_seen  = chan.tone_raw &
                        (chan.phase_reversal_ignore | chan.phase_rev);
    assign gated_tone = tone_seen & chan.auto_tone_bypass_en;
    assign change_evt = chan.path_change & chan.path_change_detect_en;

    ecsp_byte_t status_nxt;
    always_comb begin
        status_nxt                  = `ECSP_STATUS_RST;
        status_nxt[`ECSP_ST_TONE]   = tone_seen;
        status_nxt[`ECSP_ST_DTALK]  = chan.double_talk;
        status_nxt[`ECSP_ST_GATED]  = gated_tone;
        status_nxt[`ECSP_ST_NBAND]  = chan.narrowband;
    end

    // ------------------------------------------------------------
    // Flops: flags follow the detectors every cycle
    // ------------------------------------------------------------
    always_ff @(posedge chan.clk) begin
        if (!chan.rst_n) begin
            chan.status    <= `ECSP_STATUS_RST;
            chan.bypass    <= 1'b0;
            chan.est_clear <= 1'b0;
            chan.fast_conv <= 1'b0;
        end else begin
            chan.status    <= status_nxt;
            chan.bypass    <= gated_tone;
            chan.est_clear <= change_evt &
                              chan.estimate_clear_on_change;
            chan.fast_conv <= change_evt;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_GATED_TONE: assert property (
        @(posedge chan.clk) disable iff (!chan.rst_n)
        chan.status[`ECSP_ST_GATED] |->
            $past(chan.auto_tone_bypass_en) && $past(tone_seen))
        else $error("gated tone flag without enable and tone");
    AST_CLEAR_NEEDS_DET: assert property (
        @(posedge chan.clk) disable iff (!chan.rst_n)
        chan.est_clear |-> $past(chan.path_change_detect_en) &&
                           $past(chan.estimate_clear_on_change))
        else $error("estimate cleared while detection disabled");
    AST_FAST_CONV: assert property (
        @(posedge chan.clk) disable iff (!chan.rst_n)
        (chan.path_change && chan.path_change_detect_en) |=>
            chan.fast_conv)
        else $error("path change did not start fast convergence");
    AST_BYPASS_TONE: assert property (
        @(posedge chan.clk) disable iff (!chan.rst_n)
        (!chan.auto_tone_bypass_en) |=> !chan.bypass)
        else $error("bypass taken with auto bypass disabled");
endmodule : ecsp_canceller
`default_nettype wire

// [ecsp_top.sv]
// Status and path-control register slice for one canceller pair
//
// What this block does
// - Status registers at 0x02 and 0x22, reset zero
// - Path control at 0x08 and 0x28, read/write
// - Status bit 6 follows qualified tone detector
// - Status bit 5 follows double-talk detector
// - Status bit 1 is tone AND auto bypass
// - Status bit 0 follows narrow-band detector
// - Control bit 1 enables path-change detector
// - Bit 2 high: clear estimate, fast converge
// - Bit 2 low: keep estimate, fast converge
// - Clear setting ignored when detection disabled
// - Auto bypass enable bypasses on tone
// - Phase-reversal ignore widens tone trigger
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "ecsp_cfg.svh"
module ecsp_top
    import ecsp_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]        wdata,
    input  wire logic              wr_stb,
    input  wire logic              rd_stb,
    output var  logic [7:0]        rdata,
    // Detector outputs, index 0 = canceller A, 1 = canceller B
    input  wire logic [1:0]        tone_2100,
    input  wire logic [1:0]        phase_rev_seen,
    input  wire logic [1:0]        double_talk_raw,
    input  wire logic [1:0]        narrowband_raw,
    input  wire logic [1:0]        path_change_raw,
    // Actions toward the cancellers
    output logic [1:0]             bypass,
    output logic [1:0]             estimate_clear,
    output logic [1:0]             fast_converge,
    output logic [1:0]             path_detect_active,
    output logic [1:0]             instability_detector_ctl
);
    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (ADDR_W < 6) begin : g_bad_addr_w
        $error("ADDR_W must cover offsets up to 0x2F");
    end

    localparam int NCH = 2;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic ecsp_reg_e reg_sel(input logic [ADDR_W-1:0] a);
        logic [7:0] off;
        off = 8'(a & ADDR_W'(8'h1F));
        if ((a >> 6) != '0)
            reg_sel = ECSP_REG_NONE;
        else if (off == `ECSP_OFF_A_STATUS)
            reg_sel = ECSP_REG_STATUS;
        else if (off == `ECSP_OFF_A_PATH)
            reg_sel = ECSP_REG_PATH;
        else if (off == `ECSP_OFF_A_TONE)
            reg_sel = ECSP_REG_TONE;
        else
            reg_sel = ECSP_REG_NONE;
    endfunction : reg_sel

    function automatic logic bank_of(input logic [ADDR_W-1:0] a);
        bank_of = a[5];
    endfunction : bank_of

    wire ecsp_reg_e sel;
    wire logic      bank;
    assign sel  = reg_sel(addr);
    assign bank = bank_of(addr);

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    ecsp_byte_t path_ctl_r  [NCH];
    ecsp_byte_t path_ctl_nxt[NCH];
    ecsp_byte_t tone_cfg_r  [NCH];
    ecsp_byte_t tone_cfg_nxt[NCH];
    ecsp_byte_t status_v    [NCH];

    wire logic wr_path [NCH];
    wire logic wr_tone [NCH];

    ecsp_chan_if chan_if [NCH] (.clk(clk), .rst_n(rst_n));

    for (genvar g = 0; g < NCH; g++) begin : g_ch
        assign wr_path[g] = wr_stb && (sel == ECSP_REG_PATH) &&
                            (bank == 1'(g));
        assign wr_tone[g] = wr_stb && (sel == ECSP_REG_TONE) &&
                            (bank == 1'(g));
        // Reserved control bits are not stored and read as zero
        assign path_ctl_nxt[g] = wr_path[g] ?
                                 (wdata & `ECSP_PATH_WMASK) :
                                 path_ctl_r[g];
        assign tone_cfg_nxt[g] = wr_tone[g] ?
                                 (wdata & `ECSP_TONE_WMASK) :
                                 tone_cfg_r[g];

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                path_ctl_r[g] <= `ECSP_PATH_RST;
                tone_cfg_r[g] <= `ECSP_TONE_RST;
            end else begin
                path_ctl_r[g] <= path_ctl_nxt[g];
                tone_cfg_r[g] <= tone_cfg_nxt[g];
            end
        end

        // --------------------------------------------------------
        // Canceller flag logic
        // --------------------------------------------------------
        assign chan_if[g].tone_raw    = tone_2100[g];
        assign chan_if[g].phase_rev   = phase_rev_seen[g];
        assign chan_if[g].double_talk = double_talk_raw[g];
        assign chan_if[g].narrowband  = narrowband_raw[g];
        assign chan_if[g].path_change = path_change_raw[g];
        assign chan_if[g].auto_tone_bypass_en =
            tone_cfg_r[g][`ECSP_TC_AUTO];
        assign chan_if[g].phase_reversal_ignore =
            tone_cfg_r[g][`ECSP_TC_PHREV];
        assign chan_if[g].path_change_detect_en =
            path_ctl_r[g][`ECSP_PC_DET];
        assign chan_if[g].estimate_clear_on_change =
            path_ctl_r[g][`ECSP_PC_CLR];

        ecsp_canceller u_canceller (
            .chan (chan_if[g])
        );

        assign status_v[g]       = chan_if[g].status;
        assign bypass[g]         = chan_if[g].bypass;
        assign estimate_clear[g] = chan_if[g].est_clear;
        assign fast_converge[g]  = chan_if[g].fast_conv;
        assign path_detect_active[g] =
            path_ctl_r[g][`ECSP_PC_DET];
        assign instability_detector_ctl[g] =
            path_ctl_r[g][`ECSP_PC_INSTAB];
    end

    // ------------------------------------------------------------
    // Read path: data stand one cycle after the read strobe
    // ------------------------------------------------------------
    ecsp_byte_t rd_mux;
    always_comb begin
        unique case (sel)
            ECSP_REG_STATUS: rd_mux = status_v[bank];
            ECSP_REG_PATH:   rd_mux = path_ctl_r[bank];
            ECSP_REG_TONE:   rd_mux = tone_cfg_r[bank];
            ECSP_REG_NONE:   rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            rdata <= 8'h00;
        else
            rdata <= rd_stb ? rd_mux : 8'h00;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_STATUS_A_READ: assert property (
        @(posedge clk) disable iff (!rst_n)
        (rd_stb && addr == ADDR_W'(`ECSP_OFF_A_STATUS)) |=>
            rdata == $past(chan_if[0].status))
        else $error("status A read returned wrong value");

    AST_STATUS_B_READ: assert property (
        @(posedge clk) disable iff (!rst_n)
        (rd_stb && addr == ADDR_W'(`ECSP_OFF_B_STATUS)) |=>
            rdata == $past(chan_if[1].status))
        else $error("status B read returned wrong value");

    AST_STATUS_RESET: assert property (
        @(posedge clk)
        $past(!rst_n) |-> chan_if[0].status == `ECSP_STATUS_RST &&
                          chan_if[1].status == `ECSP_STATUS_RST)
        else $error("status not zero after reset");

    AST_PATH_RESET: assert property (
        @(posedge clk)
        $past(!rst_n) |-> path_ctl_r[0] == `ECSP_PATH_RST &&
                          path_ctl_r[1] == `ECSP_PATH_RST)
        else $error("path control not at reset value");

    AST_PATH_B_WRITE: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_stb && addr == ADDR_W'(`ECSP_OFF_B_PATH)) ##1
            (rd_stb && addr == ADDR_W'(`ECSP_OFF_B_PATH)) |=>
            rdata == ($past(wdata, 2) & `ECSP_PATH_WMASK))
        else $error("path control B write not read back");

    AST_PATH_A_WRITE: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_stb && addr == ADDR_W'(`ECSP_OFF_A_PATH)) |=>
            path_detect_active[0] == $past(wdata[`ECSP_PC_DET]))
        else $error("path detect enable A not taken from write");

    AST_TONE_FLAG: assert property (
        @(posedge clk) disable iff (!rst_n)
        (tone_2100[0] && phase_rev_seen[0]) |=>
            chan_if[0].status[`ECSP_ST_TONE])
        else $error("tone flag missing while tone present");

    AST_PHREV_QUAL: assert property (
        @(posedge clk) disable iff (!rst_n)
        (tone_2100[1] && !phase_rev_seen[1] &&
         !tone_cfg_r[1][`ECSP_TC_PHREV]) |=>
            !chan_if[1].status[`ECSP_ST_TONE])
        else $error("tone flag without phase reversal");

    AST_DTALK_FLAG: assert property (
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> chan_if[1].status[`ECSP_ST_DTALK] ==
                 $past(double_talk_raw[1]))
        else $error("double-talk flag does not follow detector");

    AST_NBAND_FLAG: assert property (
        @(posedge clk) disable iff (!rst_n)
        narrowband_raw[0] ##1 !narrowband_raw[0] |->
            chan_if[0].status[`ECSP_ST_NBAND] ##1
            !chan_if[0].status[`ECSP_ST_NBAND])
        else $error("narrow-band flag not following detector");

    AST_RSVD_ZERO: assert property (
        @(posedge clk) disable iff (!rst_n)
        $past(rd_stb) && $past(sel) == ECSP_REG_STATUS |->
            rdata[7] == 1'b0 && rdata[4:2] == 3'h0)
        else $error("reserved status bit read nonzero");

    AST_STATUS_NO_WRITE: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_stb && sel == ECSP_REG_STATUS) |=>
            $stable(path_ctl_r[0]) && $stable(path_ctl_r[1]))
        else $error("status write disturbed control state");

    AST_CLEAR_DISABLED: assert property (
        @(posedge clk) disable iff (!rst_n)
        !path_detect_active[1] [*2] |-> !estimate_clear[1])
        else $error("estimate cleared with detection off");

    AST_CLEAR_ON_CHANGE: assert property (
        @(posedge clk) disable iff (!rst_n)
        (path_change_raw[0] && path_ctl_r[0][`ECSP_PC_DET] &&
         path_ctl_r[0][`ECSP_PC_CLR]) |=>
            estimate_clear[0] && fast_converge[0])
        else $error("path change did not clear estimate");

    AST_KEEP_ON_CHANGE: assert property (
        @(posedge clk) disable iff (!rst_n)
        (path_change_raw[1] && path_ctl_r[1][`ECSP_PC_DET] &&
         !path_ctl_r[1][`ECSP_PC_CLR]) |=>
            !estimate_clear[1] && fast_converge[1])
        else $error("estimate not kept on path change");

    AST_NO_DET_NO_ACT: assert property (
        @(posedge clk) disable iff (!rst_n)
        (path_change_raw[0] && !path_ctl_r[0][`ECSP_PC_DET]) |=>
            !fast_converge[0])
        else $error("disabled detector reacted to path change");

    AST_BYPASS_ON_TONE: assert property (
        @(posedge clk) disable iff (!rst_n)
        (tone_2100[0] && tone_cfg_r[0][`ECSP_TC_AUTO] &&
         tone_cfg_r[0][`ECSP_TC_PHREV]) |=>
            bypass[0] && chan_if[0].status[`ECSP_ST_GATED])
        else $error("auto bypass not taken on tone");

    AST_LIVE_FLAGS: assert property (
        @(posedge clk) disable iff (!rst_n)
        double_talk_raw[0] ##1 !double_talk_raw[0] |=>
            !chan_if[0].status[`ECSP_ST_DTALK])
        else $error("status flag latched instead of live");

    AST_RDATA_IDLE: assert property (
        @(posedge clk) disable iff (!rst_n)
        !rd_stb |=> rdata == 8'h00)
        else $error("read data outside the read answer cycle");

    AST_PATH_A_READ: assert property (
        @(posedge clk) disable iff (!rst_n)
        (rd_stb && sel == ECSP_REG_PATH && !bank) |=> rdata == path_ctl_r[0])
        else $error("path control A read returned wrong value");

    AST_PATH_B_READ: assert property (
        @(posedge clk) disable iff (!rst_n)
        (rd_stb && sel == ECSP_REG_PATH && bank) |=> rdata == path_ctl_r[1])
        else $error("path control B read returned wrong value");

    AST_UNMAPPED_READ: assert property (
        @(posedge clk) disable iff (!rst_n)
        (rd_stb && sel == ECSP_REG_NONE) |=> rdata == 8'h00)
        else $error("unmapped read returned nonzero");

    AST_NO_TONE_A: assert property (
        @(posedge clk) disable iff (!rst_n)
        !tone_2100[0] |=> !status_v[0][`ECSP_ST_TONE])
        else $error("tone flag set without tone");

    AST_TONE_B_FLAG: assert property (
        @(posedge clk) disable iff (!rst_n)
        (tone_2100[1] && tone_cfg_r[1][`ECSP_TC_PHREV]) |=>
            status_v[1][`ECSP_ST_TONE])
        else $error("tone flag missing with reversal ignored");

    AST_DTALK_A: assert property (
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> status_v[0][`ECSP_ST_DTALK] == $past(double_talk_raw[0]))
        else $error("double-talk flag A does not follow detector");

    AST_NBAND_B: assert property (
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> status_v[1][`ECSP_ST_NBAND] == $past(narrowband_raw[1]))
        else $error("narrow-band flag B does not follow detector");

    AST_GATED_NEEDS_AUTO: assert property (
        @(posedge clk) disable iff (!rst_n)
        !tone_cfg_r[1][`ECSP_TC_AUTO] |=> !status_v[1][`ECSP_ST_GATED])
        else $error("gated tone flag with auto bypass off");

    AST_INSTAB_B_WRITE: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_stb && addr == ADDR_W'(`ECSP_OFF_B_PATH)) |=>
            instability_detector_ctl[1] == $past(wdata[`ECSP_PC_INSTAB]))
        else $error("instability control B not taken from write");

    AST_BYPASS_OFF: assert property (
        @(posedge clk) disable iff (!rst_n)
        !tone_2100[1] |=> !bypass[1])
        else $error("bypass taken without tone");
endmodule : ecsp_top
`default_nettype wire

// [ecsp_bench.sv]
// Self-checking bench for the canceller status and path-control slice
`timescale 1ns/1ns
`default_nettype none
`include "ecsp_cfg.svh"
module ecsp_bench
    import ecsp_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic       clk;
    logic       rst_n;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr_stb;
    logic       rd_stb;
    logic [7:0] rdata;
    logic [1:0] tone_2100;
    logic [1:0] phase_rev_seen;
    logic [1:0] double_talk_raw;
    logic [1:0] narrowband_raw;
    logic [1:0] path_change_raw;
    logic [1:0] bypass;
    logic [1:0] estimate_clear;
    logic [1:0] fast_converge;
    logic [1:0] path_detect_active;
    logic [1:0] instability_detector_ctl;
    logic       act_stb;
    logic       rd_seen;
    logic       act_seen;
    ecsp_byte_t ctl_m [2];
    ecsp_byte_t tcfg_m [2];
    ecsp_byte_t exp_rd [$];
    logic [9:0] exp_act [$];
    int         n_fail;
    int         n_compared;
    int         cycles;

    ecsp_top #(.ADDR_W(6)) uut (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .tone_2100(tone_2100), .phase_rev_seen(phase_rev_seen),
        .double_talk_raw(double_talk_raw), .narrowband_raw(narrowband_raw),
        .path_change_raw(path_change_raw), .bypass(bypass),
        .estimate_clear(estimate_clear), .fast_converge(fast_converge),
        .path_detect_active(path_detect_active),
        .instability_detector_ctl(instability_detector_ctl)
    );

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------
    function automatic logic tone_q(input int c, input logic t,
                                    input logic p);
        return t & (p | tcfg_m[c][`ECSP_TC_PHREV]);
    endfunction : tone_q

    function automatic ecsp_byte_t stat_of(input int c);
        logic t;
        t = tone_q(c, tone_2100[c], phase_rev_seen[c]);
        return {1'h0, t, double_talk_raw[c], 3'h0,
                t & tcfg_m[c][`ECSP_TC_AUTO], narrowband_raw[c]};
    endfunction : stat_of

    function automatic ecsp_byte_t exp_reg(input logic [5:0] a);
        case ({2'h0, a})
            `ECSP_OFF_A_STATUS: return stat_of(0);
            `ECSP_OFF_B_STATUS: return stat_of(1);
            `ECSP_OFF_A_PATH:   return ctl_m[0];
            `ECSP_OFF_B_PATH:   return ctl_m[1];
            `ECSP_OFF_A_TONE:   return tcfg_m[0];
            `ECSP_OFF_B_TONE:   return tcfg_m[1];
            default:            return 8'h00;
        endcase
    endfunction : exp_reg

    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    task automatic rd(input logic [5:0] a);
        addr <= a;
        rd_stb <= 1'h1;
        wr_stb <= 1'h0;
        act_stb <= 1'h0;
        path_change_raw <= 2'h0;
        exp_rd.push_back(exp_reg(a));
        @(posedge clk);
    endtask : rd

    task automatic wr(input logic [5:0] a, input ecsp_byte_t d);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'h1;
        rd_stb <= 1'h0;
        act_stb <= 1'h0;
        path_change_raw <= 2'h0;
        case ({2'h0, a})
            `ECSP_OFF_A_PATH: ctl_m[0] = d & `ECSP_PATH_WMASK;
            `ECSP_OFF_B_PATH: ctl_m[1] = d & `ECSP_PATH_WMASK;
            `ECSP_OFF_A_TONE: tcfg_m[0] = d & `ECSP_TONE_WMASK;
            `ECSP_OFF_B_TONE: tcfg_m[1] = d & `ECSP_TONE_WMASK;
            default: ;
        endcase
        @(posedge clk);
    endtask : wr

    // Drive detector levels and note the action outputs one cycle on
    task automatic stim(input logic [1:0] tn, input logic [1:0] pr,
                        input logic [1:0] dt, input logic [1:0] nb,
                        input logic [1:0] pc);
        logic [1:0] byp;
        logic [1:0] ec;
        logic [1:0] fc;
        for (int c = 0; c < 2; c++) begin
            byp[c] = tone_q(c, tn[c], pr[c]) & tcfg_m[c][`ECSP_TC_AUTO];
            fc[c] = pc[c] & ctl_m[c][`ECSP_PC_DET];
            ec[c] = fc[c] & ctl_m[c][`ECSP_PC_CLR];
        end
        tone_2100 <= tn;
        phase_rev_seen <= pr;
        double_talk_raw <= dt;
        narrowband_raw <= nb;
        path_change_raw <= pc;
        act_stb <= 1'h1;
        rd_stb <= 1'h0;
        wr_stb <= 1'h0;
        exp_act.push_back({byp, ec, fc,
            ctl_m[1][`ECSP_PC_DET], ctl_m[0][`ECSP_PC_DET],
            ctl_m[1][`ECSP_PC_INSTAB], ctl_m[0][`ECSP_PC_INSTAB]});
        @(posedge clk);
    endtask : stim

    task automatic idle();
        rd_stb <= 1'h0;
        wr_stb <= 1'h0;
        act_stb <= 1'h0;
        path_change_raw <= 2'h0;
        @(posedge clk);
    endtask : idle

    // ------------------------------------------------------------
    // Monitor and verdict
    // ------------------------------------------------------------
    task automatic check(input logic [9:0] e, input logic [9:0] g);
        n_compared++;
        if (e !== g) begin
            n_fail++;
            $display("unexpected at %0t: expected %h got %h", $time, e, g);
        end
    endtask : check

    always @(posedge clk) begin
        rd_seen <= rd_stb;
        act_seen <= act_stb;
        if (rd_seen === 1'h1) begin
            check((exp_rd.size() > 0) ? {2'h0, exp_rd.pop_front()} : 'x,
                  {2'h0, rdata});
        end
        if (act_seen === 1'h1) begin
            check((exp_act.size() > 0) ? exp_act.pop_front() : 'x,
                  {bypass, estimate_clear, fast_converge,
                   path_detect_active, instability_detector_ctl});
        end
        // Hang guard well above the length of the sequence below
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0 && exp_rd.size() == 0
            && exp_act.size() == 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'h0;
        {addr, wdata, wr_stb, rd_stb, act_stb} = '0;
        {tone_2100, phase_rev_seen, double_talk_raw} = '0;
        {narrowband_raw, path_change_raw} = '0;
        ctl_m = '{`ECSP_PATH_RST, `ECSP_PATH_RST};
        tcfg_m = '{`ECSP_TONE_RST, `ECSP_TONE_RST};
        void'($urandom(32'h4B45F1C6));
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        // Reset values, back-to-back reads
        rd(6'h02);
        rd(6'h22);
        rd(6'h08);
        rd(6'h28);
        stim(2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
        // Unmapped places and writes to read-only status
        rd(6'h03);
        rd(6'h3F);
        wr(6'h02, 8'hFF);
        wr(6'h22, 8'hFF);
        rd(6'h02);
        rd(6'h22);
        wr(6'h08, 8'hFF);
        rd(6'h08);
        // Every path setting on both cancellers, pulse held two cycles
        for (int i = 0; i < 8; i++) begin
            wr(6'h08, 8'(i * 2));
            wr(6'h28, 8'(14 - i * 2));
            rd(6'h28);
            rd(6'h08);
            stim(2'h0, 2'h0, 2'h0, 2'h0, 2'h3);
            stim(2'h0, 2'h0, 2'h0, 2'h0, 2'h3);
            stim(2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
        end
        // Random detector levels and tone configuration
        for (int i = 0; i < 60; i++) begin
            wr(6'h01, 8'($urandom));
            wr(6'h21, 8'($urandom));
            wr(6'h08, 8'($urandom) & 8'h0E);
            stim(2'($urandom), 2'($urandom), 2'($urandom), 2'($urandom),
                 2'($urandom));
            rd(6'h02);
            rd(6'h22);
            rd(6'h01);
            stim(2'($urandom), 2'($urandom), 2'($urandom), 2'($urandom),
                 2'h0);
            rd(6'h02);
            rd(6'h22);
        end
        idle();
        repeat (3) @(posedge clk);
        finish_test();
    end
endmodule : ecsp_bench
`default_nettype wire
